// *** hdl/pft_pkg.sv ***
// Package with register map, field layout and reset values of the power/fault/trace slice.
package pft_pkg;
  localparam logic [11:0] PFT_SRAM_PWR_DIS_OFS = 12'h144;
  localparam logic [11:0] PFT_FLASH_PWR_DIS_OFS = 12'h148;
  localparam logic [11:0] PFT_INSTR_FAULT_ADDR_OFS = 12'h1C0;
  localparam logic [11:0] PFT_DATA_FAULT_ADDR_OFS = 12'h1C4;
  localparam logic [11:0] PFT_SYS_FAULT_ADDR_OFS = 12'h1C8;
  localparam logic [11:0] PFT_FAULT_FLAGS_OFS = 12'h1CC;
  localparam logic [11:0] PFT_CAPTURE_EN_OFS = 12'h1D0;
  localparam logic [11:0] PFT_TRACE_CTRL_OFS = 12'h250;
  localparam logic [11:0] PFT_IRQ_MASK_OFS = 12'h260;
  localparam int PFT_SRAM_BANKS = 8;
  localparam int PFT_FLASH_BANKS = 2;
  localparam int PFT_FLAG_INSTR_BIT = 0;
  localparam int PFT_FLAG_DATA_BIT = 1;
  localparam int PFT_FLAG_SYS_BIT = 2;
  localparam int PFT_CAPTURE_EN_BIT = 0;
  localparam int PFT_TRACE_EN_BIT = 0;
  localparam int PFT_TRACE_SEL_LSB = 8;
  localparam int PFT_TRACE_SEL_MSB = 9;
  localparam logic [31:0] PFT_RESET_VALUE = 32'h0000_0000;
  typedef enum logic [1:0] {
    PFT_TRACE_OFF = 2'h0,
    PFT_TRACE_6MHZ = 2'h1,
    PFT_TRACE_3MHZ = 2'h2,
    PFT_TRACE_1M5HZ = 2'h3
  } pft_trace_sel_t;
endpackage

// *** hdl/pft_fault_capture.sv ***
// One bus fault monitor: a sticky detected flag and its held address.
`timescale 1ns/1ns
`default_nettype none
module pft_fault_capture (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic capture_en_i,
  input wire logic fault_i,
  input wire logic [31:0] addr_i,
  input wire logic clear_i,
  output logic flag_o,
  output logic [31:0] addr_o
);
  logic next_flag;
  logic [31:0] next_addr;
  logic take;

  always_comb begin
    take = capture_en_i && fault_i && !flag_o;
    next_flag = flag_o;
    next_addr = addr_o;
    if (clear_i) begin
      next_flag = 1'b0;
    end
    // A fault in the clearing cycle is kept only if the flag was already clear; a set flag blocks the capture, so it is lost.
    if (take) begin
      next_flag = 1'b1;
      next_addr = addr_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_o <= 1'b0;
      addr_o <= 32'h0000_0000;
    end else begin
      flag_o <= next_flag;
      addr_o <= next_addr;
    end
  end
endmodule
`default_nettype wire

// *** hdl/pft_ctrl.sv ***
// APB register slice for memory bank power, bus fault capture and trace port control.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Eight SRAM power-disable bits 7:0 remove bank power, and access to a removed bank faults.
// - Two flash power-disable bits 1:0 remove instance power, and access to it faults.
// - A fault captures the 32-bit instruction fetch bus address into a read-only register.
// - A fault captures the 32-bit data fetch bus address into its own read-only register.
// - A fault captures the 32-bit system bus address into a third read-only register.
// - A captured address is held until its detected flag is cleared.
// - Flag bit 2 marks a system fault, bit 1 a data fault and bit 0 an instruction fault.
// - Any write to the flag register clears all three flags together.
// - Capture enable bit 0 turns the fault monitors on when one.
// - Trace clock select 9:8 picks off, 6 MHz, 3 MHz or 1.5 MHz.
// - Trace enable bit 0 turns the trace port and its serial wire output on.
module pft_ctrl
  import pft_pkg::*;
#(
  parameter int SRAM_BANKS = PFT_SRAM_BANKS,
  parameter int FLASH_BANKS = PFT_FLASH_BANKS
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [SRAM_BANKS-1:0] sram_access_i,
  input wire logic [FLASH_BANKS-1:0] flash_access_i,
  input wire logic instr_fault_i,
  input wire logic [31:0] instr_addr_i,
  input wire logic data_fault_i,
  input wire logic [31:0] data_addr_i,
  input wire logic sys_fault_i,
  input wire logic [31:0] sys_addr_i,
  output logic [SRAM_BANKS-1:0] sram_bank_power_disable_o,
  output logic [FLASH_BANKS-1:0] flash_bank_power_disable_o,
  output logic hard_fault_o,
  output logic trace_enable_o,
  output logic [1:0] trace_clock_select_o,
  output logic trace_clk_en_o,
  output logic irq_o
);
  // Trace strobe divisors from the 50 MHz clock: about 6, 3 and 1.5 MHz.
  localparam logic [5:0] DIV_6MHZ = 6'd8;
  localparam logic [5:0] DIV_3MHZ = 6'd16;
  localparam logic [5:0] DIV_1M5HZ = 6'd33;

  logic [SRAM_BANKS-1:0] sram_dis, next_sram_dis;
  logic [FLASH_BANKS-1:0] flash_dis, next_flash_dis;
  logic capture_en, next_capture_en;
  logic trace_en, next_trace_en;
  logic [1:0] trace_sel, next_trace_sel;
  logic [2:0] irq_mask, next_irq_mask;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_hard_fault, next_irq;
  logic [5:0] div_cnt, next_div_cnt, div_top;
  logic next_trace_clk_en;
  logic wr_access, rd_access, flags_clear;
  logic [2:0] flags;
  logic [31:0] instr_held, data_held, sys_held;

  assign wr_access = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_access = psel_i && !penable_i && !pwrite_i;
  assign flags_clear = wr_access && (paddr_i == PFT_FAULT_FLAGS_OFS);

  pft_fault_capture u_instr (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .capture_en_i(capture_en),
    .fault_i(instr_fault_i),
    .addr_i(instr_addr_i),
    .clear_i(flags_clear),
    .flag_o(flags[PFT_FLAG_INSTR_BIT]),
    .addr_o(instr_held)
  );

  pft_fault_capture u_data (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .capture_en_i(capture_en),
    .fault_i(data_fault_i),
    .addr_i(data_addr_i),
    .clear_i(flags_clear),
    .flag_o(flags[PFT_FLAG_DATA_BIT]),
    .addr_o(data_held)
  );

  pft_fault_capture u_sys (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .capture_en_i(capture_en),
    .fault_i(sys_fault_i),
    .addr_i(sys_addr_i),
    .clear_i(flags_clear),
    .flag_o(flags[PFT_FLAG_SYS_BIT]),
    .addr_o(sys_held)
  );

  // Register writes; only the documented field bits are stored.
  always_comb begin
    next_sram_dis = sram_dis;
    next_flash_dis = flash_dis;
    next_capture_en = capture_en;
    next_trace_en = trace_en;
    next_trace_sel = trace_sel;
    next_irq_mask = irq_mask;
    if (wr_access) begin
      if (paddr_i == PFT_SRAM_PWR_DIS_OFS) begin
        next_sram_dis = pwdata_i[SRAM_BANKS-1:0];
      end else if (paddr_i == PFT_FLASH_PWR_DIS_OFS) begin
        next_flash_dis = pwdata_i[FLASH_BANKS-1:0];
      end else if (paddr_i == PFT_CAPTURE_EN_OFS) begin
        next_capture_en = pwdata_i[PFT_CAPTURE_EN_BIT];
      end else if (paddr_i == PFT_TRACE_CTRL_OFS) begin
        next_trace_en = pwdata_i[PFT_TRACE_EN_BIT];
        next_trace_sel = pwdata_i[PFT_TRACE_SEL_MSB:PFT_TRACE_SEL_LSB];
      end else if (paddr_i == PFT_IRQ_MASK_OFS) begin
        next_irq_mask = pwdata_i[2:0];
      end
    end
  end

  // Read data is registered in the setup cycle so pready can rise at once.
  always_comb begin
    next_prdata = prdata_o;
    next_pslverr = 1'b0;
    next_pready = psel_i && !penable_i;
    if (rd_access) begin
      next_prdata = PFT_RESET_VALUE;
      if (paddr_i == PFT_SRAM_PWR_DIS_OFS) begin
        next_prdata[SRAM_BANKS-1:0] = sram_dis;
      end else if (paddr_i == PFT_FLASH_PWR_DIS_OFS) begin
        next_prdata[FLASH_BANKS-1:0] = flash_dis;
      end else if (paddr_i == PFT_INSTR_FAULT_ADDR_OFS) begin
        next_prdata = instr_held;
      end else if (paddr_i == PFT_DATA_FAULT_ADDR_OFS) begin
        next_prdata = data_held;
      end else if (paddr_i == PFT_SYS_FAULT_ADDR_OFS) begin
        next_prdata = sys_held;
      end else if (paddr_i == PFT_FAULT_FLAGS_OFS) begin
        next_prdata[2:0] = flags;
      end else if (paddr_i == PFT_CAPTURE_EN_OFS) begin
        next_prdata[PFT_CAPTURE_EN_BIT] = capture_en;
      end else if (paddr_i == PFT_TRACE_CTRL_OFS) begin
        next_prdata[PFT_TRACE_EN_BIT] = trace_en;
        next_prdata[PFT_TRACE_SEL_MSB:PFT_TRACE_SEL_LSB] = trace_sel;
      end else if (paddr_i == PFT_IRQ_MASK_OFS) begin
        next_prdata[2:0] = irq_mask;
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel_i && !penable_i) begin
      // Writes to unmapped words are flagged as errors too.
      next_pslverr = !((paddr_i == PFT_SRAM_PWR_DIS_OFS) ||
                       (paddr_i == PFT_FLASH_PWR_DIS_OFS) ||
                       (paddr_i == PFT_INSTR_FAULT_ADDR_OFS) ||
                       (paddr_i == PFT_DATA_FAULT_ADDR_OFS) ||
                       (paddr_i == PFT_SYS_FAULT_ADDR_OFS) ||
                       (paddr_i == PFT_FAULT_FLAGS_OFS) ||
                       (paddr_i == PFT_CAPTURE_EN_OFS) ||
                       (paddr_i == PFT_TRACE_CTRL_OFS) ||
                       (paddr_i == PFT_IRQ_MASK_OFS));
    end
  end

  // Hard fault for any access to a powered-down bank, and the masked interrupt level.
  always_comb begin
    next_hard_fault = |(sram_access_i & sram_dis) | |(flash_access_i & flash_dis);
    // The level follows the held flags, so it trails a new fault by two cycles, one after its flag.
    next_irq = |(flags & irq_mask);
  end

  // Trace strobe divider; it stops in the off encoding to save power.
  always_comb begin
    case (pft_trace_sel_t'(trace_sel))
      PFT_TRACE_6MHZ: div_top = DIV_6MHZ;
      PFT_TRACE_3MHZ: div_top = DIV_3MHZ;
      PFT_TRACE_1M5HZ: div_top = DIV_1M5HZ;
      default: div_top = 6'd0;
    endcase
    next_div_cnt = 6'd0;
    next_trace_clk_en = 1'b0;
    if (trace_en && (div_top != 6'd0)) begin
      if (div_cnt >= div_top - 6'd1) begin
        next_trace_clk_en = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 6'd1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sram_dis <= '0;
      flash_dis <= '0;
      capture_en <= 1'b0;
      trace_en <= 1'b0;
      trace_sel <= 2'h0;
      irq_mask <= 3'h0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      hard_fault_o <= 1'b0;
      irq_o <= 1'b0;
      div_cnt <= 6'h00;
      trace_clk_en_o <= 1'b0;
    end else begin
      sram_dis <= next_sram_dis;
      flash_dis <= next_flash_dis;
      capture_en <= next_capture_en;
      trace_en <= next_trace_en;
      trace_sel <= next_trace_sel;
      irq_mask <= next_irq_mask;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      hard_fault_o <= next_hard_fault;
      irq_o <= next_irq;
      div_cnt <= next_div_cnt;
      trace_clk_en_o <= next_trace_clk_en;
    end
  end

  // Copies of control fields used by the memories and the trace port.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sram_bank_power_disable_o <= '0;
      flash_bank_power_disable_o <= '0;
      trace_enable_o <= 1'b0;
      trace_clock_select_o <= 2'h0;
    end else begin
      sram_bank_power_disable_o <= next_sram_dis;
      flash_bank_power_disable_o <= next_flash_dis;
      trace_enable_o <= next_trace_en;
      trace_clock_select_o <= next_trace_sel;
    end
  end
endmodule
`default_nettype wire

// *** tb/pft_ctrl_monitor.sv ***
// Assertion checker for the power, fault and trace register slice.
`timescale 1ns/1ns
`default_nettype none
module pft_ctrl_chk #(
  parameter int SRAM_BANKS = 8,
  parameter int FLASH_BANKS = 2
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [SRAM_BANKS-1:0] sram_access_i,
  input wire logic [FLASH_BANKS-1:0] flash_access_i,
  input wire logic [SRAM_BANKS-1:0] sram_bank_power_disable_o,
  input wire logic [FLASH_BANKS-1:0] flash_bank_power_disable_o,
  input wire logic hard_fault_o,
  input wire logic trace_enable_o,
  input wire logic [1:0] trace_clock_select_o,
  input wire logic trace_clk_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic wr;
  logic rd;
  logic hit;
  logic [31:0] pw_q;
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  assign rd = psel_i && penable_i && !pwrite_i && pready_o;
  assign hit = |(sram_access_i & sram_bank_power_disable_o)
    || |(flash_access_i & flash_bank_power_disable_o);
  always_ff @(posedge sys_clk_i) pw_q <= pwdata_i;
  ready_zero_wait_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("late ready");
  err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("stray error");
  sram_write_a: assert property (wr && paddr_i == 12'h144 |=>
    sram_bank_power_disable_o == pw_q[SRAM_BANKS-1:0]) else $error("sram bits");
  sram_hold_a: assert property (!(wr && paddr_i == 12'h144) |=>
    $stable(sram_bank_power_disable_o)) else $error("sram bits moved");
  flash_write_a: assert property (wr && paddr_i == 12'h148 |=>
    flash_bank_power_disable_o == pw_q[FLASH_BANKS-1:0]) else $error("flash bits");
  hard_fault_a: assert property (hit |=> hard_fault_o) else $error("no fault");
  no_false_fault_a: assert property (!hit |=> !hard_fault_o) else $error("false fault");
  trace_write_a: assert property (wr && paddr_i == 12'h250 |=> trace_enable_o == pw_q[0]
    && trace_clock_select_o == pw_q[9:8]) else $error("trace bits");
  trace_quiet_a: assert property (!trace_enable_o || trace_clock_select_o == 2'h0
    |=> !trace_clk_en_o) else $error("trace clock running");
  flags_rsvd_a: assert property (rd && paddr_i == 12'h1CC |-> prdata_o[31:3] == 29'h0)
    else $error("flag reserved bits");
endmodule
bind pft_ctrl pft_ctrl_chk #(.SRAM_BANKS(SRAM_BANKS), .FLASH_BANKS(FLASH_BANKS)) pft_ctrl_chk_i (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sram_access_i(sram_access_i),
  .flash_access_i(flash_access_i), .sram_bank_power_disable_o(sram_bank_power_disable_o),
  .flash_bank_power_disable_o(flash_bank_power_disable_o), .hard_fault_o(hard_fault_o),
  .trace_enable_o(trace_enable_o), .trace_clock_select_o(trace_clock_select_o),
  .trace_clk_en_o(trace_clk_en_o));
`default_nettype wire

// *** tb/pft_bus_model.sv ***
// Model of the processor bus decoders that report faults and bank accesses.
`timescale 1ns/1ns
`default_nettype none
module pft_bus_model (
  input wire logic sys_clk_i,
  input wire logic [2:0] req_i,
  input wire logic [31:0] addr_i,
  input wire logic [9:0] acc_i,
  output logic [2:0] fault_o,
  output logic [31:0] instr_o,
  output logic [31:0] data_o,
  output logic [31:0] sys_o,
  output logic [9:0] acc_o
);
  initial begin
    fault_o = 3'h0;
    acc_o = 10'h0;
    instr_o = 32'h0;
    data_o = 32'h0;
    sys_o = 32'h0;
  end
  // Idle buses toggle every cycle, so a capture outside the fault cycle cannot match by chance.
  always @(posedge sys_clk_i) begin
    fault_o <= req_i;
    acc_o <= acc_i;
    instr_o <= req_i[0] ? addr_i : ~instr_o;
    data_o <= req_i[1] ? addr_i + 32'h4 : ~data_o;
    sys_o <= req_i[2] ? addr_i + 32'h8 : ~sys_o;
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the power, fault and trace register slice.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic lerr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] maddr = 32'h0;
  logic [31:0] rdat;
  logic [2:0] req = 3'h0;
  logic [9:0] acc = 10'h0;
  wire logic [9:0] acc_w;
  wire logic [2:0] flt;
  wire logic [31:0] ia, da, sa, prdata;
  wire logic pready, pslverr, hard_fault, ten, tclk, irq;
  wire logic [7:0] sdis;
  wire logic [1:0] fdis, tsel;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [11:0] wa [6] = '{12'h144, 12'h148, 12'h1C0, 12'h1D0, 12'h250, 12'h260};
  logic [31:0] we [6] = '{32'hFF, 32'h3, 32'h0, 32'h1, 32'h301, 32'h7};
  logic [9:0] ha [4] = '{10'h001, 10'h002, 10'h200, 10'h100};
  always #10 clk = ~clk;
  pft_bus_model pft_bus_model_i (.sys_clk_i(clk), .req_i(req), .addr_i(maddr), .acc_i(acc),
    .fault_o(flt), .instr_o(ia), .data_o(da), .sys_o(sa), .acc_o(acc_w));
  pft_ctrl pft_ctrl_i (.sys_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sram_access_i(acc_w[7:0]),
    .flash_access_i(acc_w[9:8]), .instr_fault_i(flt[0]), .instr_addr_i(ia),
    .data_fault_i(flt[1]), .data_addr_i(da), .sys_fault_i(flt[2]), .sys_addr_i(sa),
    .sram_bank_power_disable_o(sdis), .flash_bank_power_disable_o(fdis),
    .hard_fault_o(hard_fault), .trace_enable_o(ten), .trace_clock_select_o(tsel),
    .trace_clk_en_o(tclk), .irq_o(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1 && ++n < 20);
    if (n == 20) n_mismatch++;
    rdat = prdata;
    lerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic fault(input logic [2:0] r, input logic [31:0] a);
    req <= r;
    maddr <= a;
    @(posedge clk);
    req <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_access;
    foreach (wa[i]) rd(wa[i], 32'h0);
    foreach (wa[i]) begin
      apb(1'h1, wa[i], 32'hFFFF_FFFF);
      rd(wa[i], we[i]);
    end
    chk({tsel, ten, fdis, sdis}, 32'h1FFF);
    apb(1'h1, 12'h300, 32'h1);
    chk(lerr, 32'h1);
    rd(12'h300, 32'h0);
  endtask
  task automatic t_trace;
    int cnt;
    for (int s = 0; s < 5; s++) begin
      apb(1'h1, 12'h250, {22'h0, s[1:0], 7'h0, s < 4});
      cnt = 0;
      repeat (40) @(posedge clk) cnt += tclk;
      chk(cnt != 0, s % 4 != 0);
    end
  endtask
  task automatic t_hard;
    apb(1'h1, 12'h144, 32'h1);
    apb(1'h1, 12'h148, 32'h2);
    foreach (ha[i]) begin
      acc <= ha[i];
      repeat (2) @(posedge clk);
      acc <= 10'h0;
      #1 chk(hard_fault, i % 2 == 0);
      @(posedge clk);
    end
  endtask
  task automatic t_capture;
    fault(3'h7, 32'h2000_0010);
    rd(12'h1CC, 32'h7);
    rd(12'h1C0, 32'h2000_0010);
    rd(12'h1C4, 32'h2000_0014);
    rd(12'h1C8, 32'h2000_0018);
    chk(irq, 32'h1);
    fault(3'h7, 32'h3000_0000);
    rd(12'h1C0, 32'h2000_0010);
    apb(1'h1, 12'h1CC, 32'h0);
    rd(12'h1CC, 32'h0);
    chk(irq, 32'h0);
    fault(3'h4, 32'h3000_0000);
    rd(12'h1C8, 32'h3000_0008);
    apb(1'h1, 12'h1CC, 32'h0);
    apb(1'h1, 12'h1D0, 32'h0);
    fault(3'h7, 32'h4000_0000);
    rd(12'h1CC, 32'h0);
    rd(12'h1C0, 32'h2000_0010);
    apb(1'h1, 12'h1D0, 32'h1);
    apb(1'h1, 12'h260, 32'h5);
    fault(3'h2, 32'h5000_0000);
    rd(12'h1CC, 32'h2);
    chk(irq, 32'h0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_access();
    t_trace();
    t_hard();
    t_capture();
    conclude();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule
`default_nettype wire
